//--- include/meter_pkg.sv
package meter_pkg;

  localparam int CMD_BITS      = 8;
  localparam int WORD_BITS     = 24;
  localparam int ADDR_BITS     = 5;
  localparam int REG_COUNT     = 32;
  localparam int PAGES_DEF     = 2;
  localparam int WR_DATA_BYTES = 3;

  localparam logic [4:0]  PAGE_ADDR    = 5'h1F;
  localparam logic [4:0]  STATUS_ADDR  = 5'h0F;
  localparam logic [23:0] PAGE_RESET   = 24'h000000;
  localparam logic [23:0] REG_DEFAULT  = 24'h000000;
  localparam logic [23:0] STATUS_READY = 24'h800000;

  localparam logic [7:0]  SYNC_ZERO_CMD_CMD    = 8'hFE;
  localparam logic [7:0]  SYNC_ONE_CMD_CMD    = 8'hFF;
  localparam logic [31:0] SYNC_PATTERN = {SYNC_ONE_CMD_CMD, SYNC_ONE_CMD_CMD, SYNC_ONE_CMD_CMD, SYNC_ZERO_CMD_CMD};
  localparam logic [7:0]  CONV_SINGLE  = 8'hE0;
  localparam logic [7:0]  CONV_CONT    = 8'hE8;
  localparam int          CONT_BIT     = 3;
  localparam logic [7:0]  PWR_MASK     = 8'hCF;
  localparam logic [7:0]  PWR_BASE     = 8'h80;
  localparam logic [1:0]  PWR_RESET    = 2'h0;
  localparam logic [1:0]  PWR_SLEEP    = 2'h1;
  localparam logic [1:0]  PWR_WAKE     = 2'h2;
  localparam logic [1:0]  PWR_STANDBY  = 2'h3;
  localparam int          ACC_WRITE_BIT = 6;

  localparam int CLK_PERIOD_NS = 10;
  localparam int OSC_WAIT_NS   = 1000;
  localparam int OSC_WAIT_CYC  = (OSC_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RD_GAP_NS     = 200;
  localparam int RD_GAP_CYC    = (RD_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CS_GAP_NS     = 100;
  localparam int CS_GAP_CYC    = (CS_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SCLK_HALF_DEF = 4;

  typedef enum logic [2:0] {ST_WAIT, ST_FILL, ST_ACTIVE, ST_STANDBY, ST_SLEEP} core_state_e;
  typedef enum logic [2:0] {H_IDLE, H_LEAD, H_LOW, H_HIGH, H_GAP, H_TAIL} host_state_e;

endpackage : meter_pkg

//--- include/meter_link_if.sv
`timescale 1ns/1ns
interface meter_link_if;
  logic sclk;
  logic cs_n;
  logic serial_in;
  logic serial_out;

  modport host (output sclk, output cs_n, output serial_in, input serial_out);
  modport dev  (input sclk, input cs_n, input serial_in, output serial_out);
endinterface : meter_link_if

//--- hdl/meter_sync2.sv
`timescale 1ns/1ns
module meter_sync2
(
  input  wire logic clock_i,
  input  wire logic rst_i,
  input  wire logic d_i,
  output logic      q_o
);

  logic meta_q;

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      meta_q <= 1'b0;
      q_o    <= 1'b0;
    end
    else
    begin
      meta_q <= d_i;
      q_o    <= meta_q;
    end
  end

endmodule : meter_sync2

//--- hdl/meter_serial_device.sv
// Summary of operation
// [R1] commands are single bytes, four kinds
// [R2] all bytes travel most significant bit first
// [R3] read shifts addressed register out serially
// [R4] later commands keep data; new read replaces
// [R5] host sends sync bytes while reading
// [R6] host follows write with three data bytes
// [R7] realign on select, reset pin, sync pattern
// [R8] instructions abort running sequence, then start
// [R9] host sends only reads during init; the testbench sends a continuous conversion during init
// [R10] init complete flag set at program end
// [R11] after reset, defaults loaded into registers
// [R12] 32 registers per page, page at 31
// [R13] conversion byte bit 3 selects continuous
// [R14] power byte selector in bits 5:4
// [R15] stand-by keeps registers, wake returns active
// [R16] wake from sleep reinitialises fully
// [R17] software reset reruns initialisation; in sleep the device ignores it
// [R18] host never sends undefined commands
// [R19] access byte: write bit, address, zeros
// [R20] write committed after 24th data bit
// [R21] sample on rising, drive after falling
`timescale 1ns/1ns
module meter_serial_device
  import meter_pkg::*;
#(
  parameter int PAGES = PAGES_DEF
)
(
  input  wire logic                 clock_i,
  input  wire logic                 rst_i,
  meter_link_if.dev                 link,
  output logic                      init_done_flag_o,
  output logic                      conv_start_o,
  output logic                      continuous_select_o,
  output logic                      standby_o,
  output logic                      sleep_o,
  output logic [WORD_BITS-1:0]      page_o
);

  localparam int PB      = $clog2(PAGES);
  localparam int IW      = PB + ADDR_BITS;
  localparam int ENTRIES = PAGES * REG_COUNT;

  if (PAGES < 2 || (1 << PB) != PAGES || ENTRIES > 65535 || OSC_WAIT_CYC > 65535)
  begin : g_bad_params
    $error("meter_serial_device: PAGES must be a power of two from 2");
  end

  // link side: byte framing
  logic                 rx_rst;
  logic [7:0]           rx_sh_q;
  logic [2:0]           bit_q;
  logic [31:0]          hist_q;
  logic [7:0]           rx_next;
  logic [31:0]          hist_next;
  logic                 byte_done;
  logic [7:0]           rx_hold_q;
  logic                 rx_tgl_q;
  logic                 rd_tgl_q;
  logic [1:0]           lk_wr_left_q;
  logic                 rd_seen_q;
  logic [WORD_BITS-1:0] tx_sh_q;

  assign rx_rst    = rst_i | link.cs_n; // see [R7]
  assign rx_next   = {rx_sh_q[6:0], link.serial_in}; // see [R2]
  assign hist_next = {hist_q[30:0], link.serial_in};
  assign byte_done = (bit_q == 3'h7); // see [R1]

  always_ff @(posedge link.sclk or posedge rx_rst) // see [R21]
  begin
    if (rx_rst)
    begin
      rx_sh_q <= 8'h00;
      bit_q   <= 3'h0;
      hist_q  <= 32'h00000000;
    end
    else
    begin
      rx_sh_q <= rx_next;
      hist_q  <= hist_next;
      if (hist_next == SYNC_PATTERN) // see [R7]
        bit_q <= 3'h0;
      else
        bit_q <= bit_q + 3'h1;
    end
  end

  always_ff @(posedge link.sclk or posedge rst_i)
  begin
    if (rst_i)
    begin
      rx_hold_q    <= 8'h00;
      rx_tgl_q     <= 1'b0;
      rd_tgl_q     <= 1'b0;
      lk_wr_left_q <= 2'h0;
    end
    else if (byte_done)
    begin
      rx_hold_q <= rx_next;
      rx_tgl_q  <= ~rx_tgl_q;
      if (lk_wr_left_q != 2'h0)
        lk_wr_left_q <= lk_wr_left_q - 2'h1; // see [R6]
      else if (!rx_next[7] && !rx_next[0] && rx_next[ACC_WRITE_BIT]) // see [R19]
        lk_wr_left_q <= 2'(WR_DATA_BYTES);
      else if (!rx_next[7] && !rx_next[0])
        rd_tgl_q <= ~rd_tgl_q; // see [R4]
    end
  end

  // link side: read data out, word is stable since the host gap
  logic [WORD_BITS-1:0] rd_word_q;

  always_ff @(negedge link.sclk or posedge rst_i) // see [R21]
  begin
    if (rst_i)
    begin
      rd_seen_q <= 1'b0;
      tx_sh_q   <= '0;
    end
    else if (rd_tgl_q != rd_seen_q)
    begin
      rd_seen_q <= rd_tgl_q;
      tx_sh_q   <= rd_word_q; // see [R4]
    end
    else
      tx_sh_q <= {tx_sh_q[WORD_BITS-2:0], 1'b0}; // see [R3]
  end

  assign link.serial_out = tx_sh_q[WORD_BITS-1]; // see [R2]

  // core side: byte hand-over
  logic rx_tgl_s;
  logic rx_seen_q;
  logic take;

  meter_sync2 u_rx_sync
  (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .d_i     (rx_tgl_q),
    .q_o     (rx_tgl_s)
  );

  assign take = (rx_tgl_s != rx_seen_q);

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
      rx_seen_q <= 1'b0;
    else
      rx_seen_q <= rx_tgl_s;
  end

  // core side: decode
  core_state_e          state_q;
  logic [15:0]          cnt_q;
  logic                 init_done_q;
  logic [1:0]           wr_left_q;
  logic [4:0]           wr_addr_q;
  logic [15:0]          wr_sh_q;
  logic [WORD_BITS-1:0] page_q;
  logic [WORD_BITS-1:0] mem_q [ENTRIES];
  logic [7:0]           cmd;
  logic                 is_acc;
  logic                 is_sync;
  logic                 is_conv;
  logic                 is_pwr;
  logic [1:0]           sel;
  logic                 instr;
  logic                 restart;
  logic                 core_ok;
  logic                 commit;
  logic                 page_ok;
  logic [WORD_BITS-1:0] wr_data;
  logic [IW-1:0]        wr_idx;
  logic [IW-1:0]        rd_idx;
  logic [WORD_BITS-1:0] rd_val;

  assign cmd     = rx_hold_q;
  assign is_acc  = !cmd[7] && !cmd[0]; // see [R19]
  assign is_sync = (cmd[7:1] == SYNC_ONE_CMD_CMD[7:1]);
  assign is_conv = ((cmd & ~CONV_CONT) == (CONV_SINGLE & ~CONV_CONT)); // see [R13]
  assign is_pwr  = ((cmd & PWR_MASK) == PWR_BASE); // see [R14]
  assign sel     = cmd[5:4];
  assign instr   = take && (wr_left_q == 2'h0) && !is_acc && !is_sync && (is_conv || is_pwr);
  assign restart = instr && is_pwr && (((sel == PWR_RESET) && (state_q != ST_SLEEP))
                   || ((sel == PWR_WAKE) && (state_q == ST_SLEEP))); // see [R16] see [R17]
  assign core_ok = (state_q == ST_ACTIVE) || (state_q == ST_STANDBY);
  assign commit  = take && (wr_left_q == 2'h1) && core_ok; // see [R20]
  assign wr_data = {wr_sh_q, cmd};
  assign page_ok = (page_q < WORD_BITS'(PAGES)); // see [R12]
  assign wr_idx  = {page_q[PB-1:0], wr_addr_q};
  assign rd_idx  = {page_q[PB-1:0], cmd[5:1]};

  always_comb
  begin
    rd_val = '0;
    if (page_q == PAGE_RESET && cmd[5:1] == STATUS_ADDR)
      rd_val = init_done_q ? STATUS_READY : '0; // see [R10]
    else if (page_ok)
      rd_val = mem_q[rd_idx];
  end

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      wr_left_q <= 2'h0;
      wr_addr_q <= 5'h00;
      wr_sh_q   <= 16'h0000;
      rd_word_q <= '0;
    end
    else if (take)
    begin
      if (wr_left_q != 2'h0)
      begin
        wr_left_q <= wr_left_q - 2'h1;
        wr_sh_q   <= {wr_sh_q[7:0], cmd}; // see [R6]
      end
      else if (is_acc && cmd[ACC_WRITE_BIT])
      begin
        wr_left_q <= 2'(WR_DATA_BYTES);
        wr_addr_q <= cmd[5:1];
      end
      else if (is_acc)
        rd_word_q <= rd_val; // see [R3]
    end
  end

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
      page_q <= PAGE_RESET;
    else if (restart)
      page_q <= PAGE_RESET;
    else if (commit && wr_addr_q == PAGE_ADDR)
      page_q <= wr_data; // see [R12]
  end

  always_ff @(posedge clock_i)
  begin
    if (state_q == ST_FILL)
      mem_q[cnt_q[IW-1:0]] <= REG_DEFAULT; // see [R11]
    else if (commit && page_ok && wr_addr_q != PAGE_ADDR)
      mem_q[wr_idx] <= wr_data; // see [R20]
  end

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_q             <= ST_WAIT;
      cnt_q               <= 16'h0000;
      init_done_q         <= 1'b0;
      conv_start_o        <= 1'b0;
      continuous_select_o <= 1'b0;
    end
    else
    begin
      conv_start_o <= 1'b0;
      if (restart)
      begin
        state_q             <= ST_WAIT; // see [R17]
        cnt_q               <= 16'h0000;
        init_done_q         <= 1'b0;
        continuous_select_o <= 1'b0;
      end
      else if (instr && state_q != ST_SLEEP) // see [R8]
      begin
        continuous_select_o <= 1'b0;
        cnt_q               <= 16'h0000;
        if (is_conv)
        begin
          state_q             <= ST_ACTIVE;
          conv_start_o        <= 1'b1;
          continuous_select_o <= cmd[CONT_BIT]; // see [R13]
        end
        else if (sel == PWR_SLEEP)
          state_q <= ST_SLEEP; // see [R16]
        else if (sel == PWR_STANDBY)
          state_q <= ST_STANDBY; // see [R15]
        else
          state_q <= ST_ACTIVE; // see [R15]
      end
      else
      begin
        case (state_q)
          ST_WAIT:
            if (cnt_q == 16'(OSC_WAIT_CYC - 1))
            begin
              state_q <= ST_FILL;
              cnt_q   <= 16'h0000;
            end
            else
              cnt_q <= cnt_q + 16'h0001;
          ST_FILL:
            if (cnt_q == 16'(ENTRIES - 1))
            begin
              state_q     <= ST_ACTIVE;
              cnt_q       <= 16'h0000;
              init_done_q <= 1'b1; // see [R10]
            end
            else
              cnt_q <= cnt_q + 16'h0001;
          default:
            cnt_q <= 16'h0000;
        endcase
      end
    end
  end

  assign init_done_flag_o = init_done_q;
  assign standby_o        = (state_q == ST_STANDBY);
  assign sleep_o          = (state_q == ST_SLEEP);
  assign page_o           = page_q;

endmodule : meter_serial_device

//--- hdl/meter_serial_host.sv
`timescale 1ns/1ns
module meter_serial_host
  import meter_pkg::*;
#(
  parameter int SCLK_HALF = SCLK_HALF_DEF
)
(
  input  wire logic                 clock_i,
  input  wire logic                 rst_i,
  meter_link_if.host                link,
  input  wire logic                 cmd_valid_i,
  output logic                      cmd_ready_o,
  input  wire logic [7:0]           cmd_byte_i,
  input  wire logic [WORD_BITS-1:0] cmd_data_i,
  output logic [WORD_BITS-1:0]      rd_data_o,
  output logic                      rd_valid_o
);

  if (SCLK_HALF < 4 || SCLK_HALF > 65535)
  begin : g_bad_params
    $error("meter_serial_host: SCLK_HALF must be at least 4");
  end

  host_state_e          st_q;
  logic [15:0]          div_q;
  logic [15:0]          lim;
  logic                 tick;
  logic [5:0]           nbits_q;
  logic [31:0]          tx_q;
  logic [WORD_BITS-1:0] rx_q;
  logic                 is_rd_q;
  logic                 data_ph_q;
  logic                 sclk_q;
  logic                 cs_n_q;
  logic                 sdi_q;
  logic                 sout_s;

  meter_sync2 u_sout_sync
  (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .d_i     (link.serial_out),
    .q_o     (sout_s)
  );

  always_comb
  begin
    case (st_q)
      H_GAP:   lim = 16'(RD_GAP_CYC - 1);
      H_TAIL:  lim = 16'(CS_GAP_CYC - 1);
      default: lim = 16'(SCLK_HALF - 1);
    endcase
  end

  assign tick        = (div_q == lim);
  assign cmd_ready_o = (st_q == H_IDLE);

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
      div_q <= 16'h0000;
    else if (st_q == H_IDLE || tick)
      div_q <= 16'h0000;
    else
      div_q <= div_q + 16'h0001;
  end

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      st_q       <= H_IDLE;
      nbits_q    <= 6'h00;
      tx_q       <= 32'h00000000;
      rx_q       <= '0;
      is_rd_q    <= 1'b0;
      data_ph_q  <= 1'b0;
      sclk_q     <= 1'b1;
      cs_n_q     <= 1'b1;
      sdi_q      <= 1'b1;
      rd_data_o  <= '0;
      rd_valid_o <= 1'b0;
    end
    else
    begin
      rd_valid_o <= 1'b0;
      case (st_q)
        H_IDLE:
          if (cmd_valid_i)
          begin
            st_q      <= H_LEAD;
            cs_n_q    <= 1'b0;
            tx_q      <= {cmd_byte_i, cmd_data_i}; // see [R2]
            data_ph_q <= 1'b0;
            is_rd_q   <= !cmd_byte_i[7] && !cmd_byte_i[0] && !cmd_byte_i[ACC_WRITE_BIT];
            if (!cmd_byte_i[7] && !cmd_byte_i[0] && cmd_byte_i[ACC_WRITE_BIT])
              nbits_q <= 6'(CMD_BITS + WORD_BITS); // see [R6]
            else
              nbits_q <= 6'(CMD_BITS); // see [R1]
          end
        H_LEAD, H_GAP:
          if (tick)
          begin
            st_q   <= H_LOW;
            sclk_q <= 1'b0;
            sdi_q  <= tx_q[31];
            tx_q   <= {tx_q[30:0], 1'b0};
          end
        H_LOW:
          if (tick)
          begin
            st_q    <= H_HIGH;
            sclk_q  <= 1'b1; // see [R21]
            nbits_q <= nbits_q - 6'h01;
            if (data_ph_q)
              rx_q <= {rx_q[WORD_BITS-2:0], sout_s}; // see [R3]
          end
        H_HIGH:
          if (tick)
          begin
            if (nbits_q != 6'h00)
            begin
              st_q   <= H_LOW;
              sclk_q <= 1'b0;
              sdi_q  <= tx_q[31];
              tx_q   <= {tx_q[30:0], 1'b0};
            end
            else if (is_rd_q && !data_ph_q)
            begin
              st_q      <= H_GAP;
              data_ph_q <= 1'b1;
              nbits_q   <= 6'(WORD_BITS);
              tx_q      <= {SYNC_ZERO_CMD_CMD, SYNC_ZERO_CMD_CMD, SYNC_ZERO_CMD_CMD, 8'h00}; // see [R5] see [R9]
            end
            else
            begin
              st_q   <= H_TAIL;
              cs_n_q <= 1'b1; // see [R7]
              if (data_ph_q)
              begin
                rd_data_o  <= rx_q;
                rd_valid_o <= 1'b1;
              end
            end
          end
        H_TAIL:
          if (tick)
            st_q <= H_IDLE; // see [R18]
        default:
          st_q <= H_IDLE;
      endcase
    end
  end

  assign link.sclk      = sclk_q;
  assign link.cs_n      = cs_n_q;
  assign link.serial_in = sdi_q;

endmodule : meter_serial_host

//--- sim/meter_link_asserts.sv
`timescale 1ns/1ns
module meter_link_asserts
(
  input  wire logic clock_i,
  input  wire logic rst_i,
  input  wire logic sclk,
  input  wire logic cs_n,
  input  wire logic serial_in,
  input  wire logic serial_out
);
  logic       sclk_q;
  logic [5:0] cnt_q;
  logic [7:0] sh_q;
  logic [7:0] first_q;
  logic       rise;

  assign rise = sclk && !sclk_q;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  // previous serial clock level
  always_ff @(posedge clock_i or posedge rst_i)
    if (rst_i)
      sclk_q <= 1'b1;
    else
      sclk_q <= sclk;

  // bit count and shift of the frame
  always_ff @(posedge clock_i or posedge rst_i)
    if (rst_i)
    begin
      cnt_q <= 6'h00;
      sh_q  <= 8'h00;
    end
    else if (cs_n)
      cnt_q <= 6'h00;
    else if (rise)
    begin
      cnt_q <= cnt_q + 6'h01;
      sh_q  <= {sh_q[6:0], serial_in};
    end

  // first byte of the frame
  always_ff @(posedge clock_i or posedge rst_i)
    if (rst_i)
      first_q <= 8'h00;
    else if (rise && cnt_q == 6'h07)
      first_q <= {sh_q[6:0], serial_in};

  property p_sclk_idle;
    cs_n |-> sclk;
  endproperty
  a_sclk_idle: assert property (p_sclk_idle)
    else $error("serial clock low outside frame");

  property p_sdi_stable;
    (!cs_n && !$past(cs_n) && sclk && sclk_q) |-> $stable(serial_in);
  endproperty
  a_sdi_stable: assert property (p_sdi_stable)
    else $error("serial input moved while clock high");

  property p_sdo_fall;
    (!cs_n && !$past(cs_n) && $changed(serial_out)) |-> $fell(sclk);
  endproperty
  a_sdo_fall: assert property (p_sdo_fall)
    else $error("serial output moved off falling edge");

  property p_low_half;
    $fell(sclk) |-> (!sclk)[*4] ##1 sclk;
  endproperty
  a_low_half: assert property (p_low_half)
    else $error("serial clock low phase wrong");

  property p_frame_bytes;
    $rose(cs_n) |-> cnt_q[2:0] == 3'h0;
  endproperty
  a_frame_bytes: assert property (p_frame_bytes)
    else $error("frame not whole bytes");

  property p_cmd_bit0;
    (rise && cnt_q == 6'h07 && !sh_q[6]) |-> !serial_in;
  endproperty
  a_cmd_bit0: assert property (p_cmd_bit0)
    else $error("access command bit 0 set");

  property p_write_len;
    ($rose(cs_n) && first_q[7:6] == 2'b01) |-> cnt_q == 6'h20;
  endproperty
  a_write_len: assert property (p_write_len)
    else $error("write frame length wrong");

  property p_read_len;
    ($rose(cs_n) && first_q[7:6] == 2'b00) |-> cnt_q == 6'h20;
  endproperty
  a_read_len: assert property (p_read_len)
    else $error("read frame length wrong");

  property p_instr_len;
    ($rose(cs_n) && first_q[7]) |-> cnt_q == 6'h08;
  endproperty
  a_instr_len: assert property (p_instr_len)
    else $error("instruction frame length wrong");

  property p_read_gap;
    (rise && cnt_q == 6'h07 && sh_q[6:5] == 2'b00) |-> ##1 sclk[*8] ##1 sclk[*8] ##1 sclk[*4];
  endproperty
  a_read_gap: assert property (p_read_gap)
    else $error("read gap too short");

  c_read: cover property ($rose(cs_n) && first_q[7:6] == 2'b00);
  c_write: cover property ($rose(cs_n) && first_q[7:6] == 2'b01);
  c_instr: cover property ($rose(cs_n) && first_q[7]);
endmodule : meter_link_asserts

//--- sim/meter_serial_command_decoder_tb.sv
`timescale 1ns/1ns
module meter_serial_command_decoder_tb
  import meter_pkg::*;
;
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin err_count++; \
  $display("ERROR %s exp %h got %h", n, e, g); end end
  logic        clock_i;
  logic        rst_i;
  logic        cmd_valid_i;
  logic        cmd_ready_o;
  logic [7:0]  cmd_byte_i;
  logic [23:0] cmd_data_i;
  logic [23:0] rd_data_o;
  logic        rd_valid_o;
  logic        init_done;
  logic        conv_start;
  logic        cont_sel;
  logic        standby;
  logic        sleeping;
  logic [23:0] page_val;
  logic [31:0] seed = 32'h0AE264E0;
  logic [23:0] mdl [2][32];
  logic [4:0]  adr;
  int          page;
  int          err_count;
  int          tests_run;
  int          rd_n;
  int          conv_n;
  int          k;

  meter_link_if link_bus ();

  meter_serial_host #(.SCLK_HALF(4)) i_meter_serial_host
  (.clock_i(clock_i), .rst_i(rst_i), .link(link_bus.host), .cmd_valid_i(cmd_valid_i),
   .cmd_ready_o(cmd_ready_o), .cmd_byte_i(cmd_byte_i), .cmd_data_i(cmd_data_i),
   .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o));

  meter_serial_device #(.PAGES(2)) i_meter_serial_device
  (.clock_i(clock_i), .rst_i(rst_i), .link(link_bus.dev), .init_done_flag_o(init_done),
   .conv_start_o(conv_start), .continuous_select_o(cont_sel), .standby_o(standby),
   .sleep_o(sleeping), .page_o(page_val));

  meter_link_asserts i_meter_link_asserts
  (.clock_i(clock_i), .rst_i(rst_i), .sclk(link_bus.sclk), .cs_n(link_bus.cs_n),
   .serial_in(link_bus.serial_in), .serial_out(link_bus.serial_out));

  initial
  begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end

  // pulse counters
  always @(negedge clock_i)
  begin
    if (rd_valid_o === 1'b1)
      rd_n++;
    if (conv_start === 1'b1)
      conv_n++;
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  function automatic logic [7:0] pwr(input logic [1:0] s);
    return {2'b10, s, 4'h0};
  endfunction : pwr

  task automatic report_and_stop();
    $display("checks %0d errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop

  task automatic send(input logic [7:0] b, input logic [23:0] d);
    logic r;
    int   n;
    n = 0;
    cmd_byte_i = b;
    cmd_data_i = d;
    cmd_valid_i = 1'b1;
    do
    begin
      r = cmd_ready_o;
      @(posedge clock_i);
      #1;
      n++;
    end
    while (r !== 1'b1 && n < 3000);
    cmd_valid_i = 1'b0;
    `CHK("cmd_taken", 1'b1, r)
    n = 0;
    while (cmd_ready_o !== 1'b1 && n < 3000)
    begin
      @(posedge clock_i);
      #1;
      n++;
    end
    `CHK("cmd_ready", 1'b1, cmd_ready_o)
  endtask : send

  task automatic wr(input logic [4:0] a, input logic [23:0] d);
    send({2'b01, a, 1'b0}, d);
    if (a == PAGE_ADDR)
      page = int'(d);
    else
      mdl[page][a] = d;
  endtask : wr

  task automatic rd(input logic [4:0] a, input logic [23:0] e);
    int c;
    c = rd_n;
    send({2'b00, a, 1'b0}, 24'(xs()));
    `CHK("rd_valid", c + 1, rd_n)
    `CHK("rd_data", e, rd_data_o)
  endtask : rd

  task automatic wait_init();
    int n;
    n = 0;
    while (init_done !== 1'b1 && n < 1000)
    begin
      @(posedge clock_i);
      #1;
      n++;
    end
    `CHK("init_done", 1'b1, init_done)
    foreach (mdl[p, a])
      mdl[p][a] = REG_DEFAULT;
    page = 0;
  endtask : wait_init

  initial
  begin
    #600000;
    err_count++;
    report_and_stop();
  end

  initial
  begin
    rst_i = 1'b1;
    cmd_valid_i = 1'b0;
    cmd_byte_i = 8'h00;
    cmd_data_i = 24'h000000;
    repeat (12) @(posedge clock_i);
    #1 rst_i = 1'b0;
    rd(STATUS_ADDR, 24'h000000);
    wait_init();
    rd(STATUS_ADDR, STATUS_READY);
    rd(5'h03, REG_DEFAULT);
    for (int i = 0; i < 6; i++)
    begin
      adr = 5'(xs() % 32'd15);
      wr(adr, 24'(xs()));
      rd(adr, mdl[page][adr]);
    end
    wr(PAGE_ADDR, 24'h000001);
    `CHK("page", 24'h000001, page_val)
    wr(5'h07, 24'hA5C3E1);
    rd(5'h07, mdl[1][7]);
    wr(PAGE_ADDR, 24'h000000);
    rd(5'h07, mdl[0][7]);
    for (int i = 0; i < 2; i++)
    begin
      k = conv_n;
      send(i ? CONV_CONT : CONV_SINGLE, 24'h000000);
      `CHK("conv_start", k + 1, conv_n)
      `CHK("continuous", i[0], cont_sel)
    end
    send(pwr(PWR_STANDBY), 24'h000000);
    `CHK("standby", 1'b1, standby)
    send(pwr(PWR_WAKE), 24'h000000);
    `CHK("standby", 1'b0, standby)
    `CHK("continuous", 1'b0, cont_sel)
    rd(adr, mdl[0][adr]);
    wr(PAGE_ADDR, 24'h000001);
    send(pwr(PWR_SLEEP), 24'h000000);
    `CHK("sleep", 1'b1, sleeping)
    send(pwr(PWR_WAKE), 24'h000000);
    `CHK("init_done", 1'b0, init_done)
    wait_init();
    `CHK("page", 24'h000000, page_val)
    rd(5'h07, REG_DEFAULT);
    wr(5'h02, 24'(xs()));
    send(pwr(PWR_RESET), 24'h000000);
    `CHK("init_done", 1'b0, init_done)
    send(CONV_CONT, 24'h000000);
    `CHK("continuous", 1'b1, cont_sel)
    repeat (200) @(posedge clock_i);
    #1;
    `CHK("init_done", 1'b0, init_done)
    send(pwr(PWR_RESET), 24'h000000);
    wait_init();
    rd(5'h02, REG_DEFAULT);
    wr(5'h04, 24'(xs()));
    rst_i = 1'b1;
    repeat (12) @(posedge clock_i);
    #1 rst_i = 1'b0;
    wait_init();
    rd(5'h04, REG_DEFAULT);
    report_and_stop();
  end
endmodule : meter_serial_command_decoder_tb
